// File: design/xir_pkg.sv
// Constants, register layout and carrier types for the X-bus decode and IRQ route slice.
// Assumes one 125 MHz clock, byte-wide configuration access and synchronous inputs.
// Operation
// [RULE_01] Micro enable set: decode I/O 62h/66h positively and assert micro select.
// [RULE_02] 1-Meg BIOS bit: FFF00000-FFF7FFFFh gets ROM select, output enable, LA ones.
// [RULE_03] APIC bit set: PCI memory to APIC window selects APIC, forwards to ISA.
// [RULE_04] APIC select never asserted for cycles coming from the ISA side.
// [RULE_05] APIC bit switches APIC pins between APIC use and general purpose use.
// [RULE_06] Extended BIOS bit: FFF80000-FFFDFFFFh gets ROM select, output enable, LA ones.
// [RULE_07] Lower BIOS bit: E0000-EFFFFh or FFFE0000 alias selects ROM; alias drives LA ones.
// [RULE_08] Lower BIOS bit clear: no select, no enable, no forwarding for that block.
// [RULE_09] Coprocessor bit: FPU error raises internal IRQ13 and gates ignore-error output.
// [RULE_10] Mouse bit makes IRQ12 input the mouse function, else plain IRQ12.
// [RULE_11] Alias bit: ports 63h, 65h, 67h act as port 61h.
// [RULE_12] ROM write bit: select on reads and writes; clear means reads only.
// [RULE_13] Keyboard bit: ports 60h/64h assert keyboard select and output enable.
// [RULE_14] Clock-chip bit: ports 70-77h assert select, address latch and output enable.
// [RULE_15] Any cleared X-bus enable suppresses its select and the shared output enable.
// [RULE_16] Route bit 7 low enables routing; codes pick IRQ3-7, 9-12, 14, 15.
// [RULE_17] Lines may share one IRQ; a routed IRQ has its own input masked.
// [RULE_18] Software programs the routed IRQ as level sensitive in edge/level control.
// [RULE_19] Serial IRQ runs only with its enable and general config bit 16 both set.
// [RULE_20] Serial mode bit: set is continuous mode, clear is quiet mode.
// [RULE_21] Frame size field is read/write, resets to 0100b, only that value is used.
// [RULE_22] Start pulse lasts 4, 6 or 8 clocks for width codes 00, 01, 10.
// [RULE_23] Width code 11 is reserved; the device falls back to a 4-clock pulse.
package xir_pkg;
   localparam logic [7:0]  OFF_XBCTL_LO   = 8'h4E;
   localparam logic [7:0]  OFF_XBCTL_HI   = 8'h4F;
   localparam logic [7:0]  OFF_ROUTE_A    = 8'h60;
   localparam logic [7:0]  OFF_ROUTE_D    = 8'h63;
   localparam logic [7:0]  OFF_SERCTL     = 8'h64;
   localparam logic [15:0] RST_XBCTL      = 16'h0003;
   localparam logic [15:0] MASK_XBCTL     = 16'h07FF;
   localparam logic [7:0]  RST_ROUTE      = 8'h80;
   localparam logic [7:0]  MASK_ROUTE     = 8'h8F;
   localparam logic [7:0]  RST_SERCTL     = 8'h10;
   // Control bit positions
   localparam int XB_RTC = 0, XB_KBC = 1, XB_ROMWE = 2, XB_ALIAS61 = 3, XB_MOUSE = 4;
   localparam int XB_FPU = 5, XB_LOWBIOS = 6, XB_EXTBIOS = 7, XB_APIC = 8;
   localparam int XB_BIOS1M = 9, XB_MICRO = 10;
   localparam int RT_DIS = 7;
   localparam int SQ_EN = 7, SQ_MODE = 6;
   // I/O addresses
   localparam logic [15:0] IO_KBC_DATA    = 16'h0060;
   localparam logic [15:0] IO_KBC_CMD     = 16'h0064;
   localparam logic [15:0] IO_MICRO_A     = 16'h0062;
   localparam logic [15:0] IO_MICRO_B     = 16'h0066;
   localparam logic [15:0] IO_PORT61      = 16'h0061;
   localparam logic [15:0] IO_PORT63      = 16'h0063;
   localparam logic [15:0] IO_PORT65      = 16'h0065;
   localparam logic [15:0] IO_PORT67      = 16'h0067;
   localparam logic [12:0] IO_RTC_BLOCK   = 13'h000E;
   // Memory windows
   localparam logic [31:0] MEM_1M_LO      = 32'hFFF00000;
   localparam logic [31:0] MEM_1M_HI      = 32'hFFF7FFFF;
   localparam logic [31:0] MEM_EXT_LO     = 32'hFFF80000;
   localparam logic [31:0] MEM_EXT_HI     = 32'hFFFDFFFF;
   localparam logic [15:0] MEM_LOWHI_SEG  = 16'hFFFE;
   localparam logic [15:0] MEM_LOW_SEG    = 16'h000E;
   localparam logic [31:0] MEM_APIC_A     = 32'hFEC00000;
   localparam logic [31:0] MEM_APIC_B     = 32'hFEC00010;
   // IRQs reachable by a route code
   localparam logic [15:0] IRQ_ROUTABLE   = 16'hDEF8;
   // Start pulse lengths in clocks
   localparam logic [3:0]  PULSE_CODE00   = 4'h4;
   localparam logic [3:0]  PULSE_CODE01   = 4'h6;
   localparam logic [3:0]  PULSE_CODE10   = 4'h8;

   typedef struct packed {
      logic        valid;
      logic        isa;
      logic        mem;
      logic        write;
      logic [31:0] addr;
   } xir_cyc_s;

   typedef struct packed {
      logic microcontrollerSelectN;
      logic firmwareRomSelectN;
      logic xbusOutputEnableN;
      logic ioapicSelectN;
      logic keyboardCtrlSelectN;
      logic clockChipSelectN;
      logic clockChipAddrLatch;
      logic laHighOnes;
      logic forwardIsa;
      logic positiveDecode;
      logic port61Hit;
   } xir_sel_s;
endpackage

// File: design/xir_start_pulse.sv
// Start-frame pulse driver for the serial interrupt line.
// Assumes the line is open drain and pulled high outside this block.
`timescale 1ns/100ps
module xir_start_pulse (
   input  wire logic       clk_sys,
   input  wire logic       rst,
   input  wire logic       start,
   input  wire logic [1:0] widthCode,
   output logic            lineOut,
   output logic            lineOe,
   output logic            busy
);
   import xir_pkg::*;

   typedef enum logic [1:0] {
      SP_IDLE  = 2'b01,
      SP_DRIVE = 2'b10
   } xir_sp_e;

   xir_sp_e    stateReg;
   logic [3:0] cntReg;
   logic [3:0] pulseLen;

   // Width code to length; reserved code falls back to four
   assign pulseLen = (widthCode == 2'h1) ? PULSE_CODE01 :            // [RULE_22]
                     (widthCode == 2'h2) ? PULSE_CODE10 : PULSE_CODE00; // [RULE_23]
   assign busy     = lineOe;

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         stateReg <= SP_IDLE;
         cntReg   <= 4'h0;
         lineOe   <= 1'b0;
         lineOut  <= 1'b1;
      end else begin
         unique case (stateReg)
            SP_IDLE: begin
               if (start) begin
                  stateReg <= SP_DRIVE;
                  cntReg   <= pulseLen - 4'h1; // [RULE_22]
                  lineOe   <= 1'b1;
                  lineOut  <= 1'b0;
               end
            end
            SP_DRIVE: begin
               if (cntReg == 4'h0) begin
                  stateReg <= SP_IDLE;
                  lineOe   <= 1'b0;
                  lineOut  <= 1'b1;
               end else begin
                  cntReg <= cntReg - 4'h1;
               end
            end
            default: stateReg <= SP_IDLE;
         endcase
      end
   end
endmodule // xir_start_pulse

// File: design/xir_bridge_cfg.sv
// X-bus chip-select decode, PCI interrupt routing and serial IRQ control.
// Assumes configuration byte accesses and decoded cycles arrive synchronous to clk_sys.
`timescale 1ns/100ps
module xir_bridge_cfg (
   input  wire logic             clk_sys,
   input  wire logic             rst,
   input  wire logic             cfgWrite,
   input  wire logic             cfgRead,
   input  wire logic [7:0]       cfgAddr,
   input  wire logic [7:0]       cfgWdata,
   output logic      [7:0]       cfgRdata,
   output logic                  cfgRdValid,
   input  wire xir_pkg::xir_cyc_s cyc,
   output xir_pkg::xir_sel_s     sel,
   output logic                  apicPinMode,
   input  wire logic             fpuErrorN,
   input  wire logic             ignNeRequest,
   output logic                  ignoreNumericErrorN,
   input  wire logic [3:0]       pciIntLinesN,
   input  wire logic [15:0]      isaIrqIn,
   output logic      [15:0]      irqToCtrl,
   output logic                  mouseIrq,
   input  wire logic             gcfgSerialIrqEn,
   input  wire logic             serialStartReq,
   input  wire logic             serialIrqLineIn,
   output logic                  serialIrqLineOut,
   output logic                  serialIrqLineOe,
   output logic                  serialIrqActive,
   output logic                  serialIrqContinuous
);
   import xir_pkg::*;

   logic [15:0]      xbusCtlReg;
   logic [3:0][7:0]  routeReg;
   logic [7:0]       serCtlReg;

   // Configuration write decode
   wire wrXbLo  = cfgWrite && (cfgAddr == OFF_XBCTL_LO);
   wire wrXbHi  = cfgWrite && (cfgAddr == OFF_XBCTL_HI);
   wire wrSer   = cfgWrite && (cfgAddr == OFF_SERCTL);
   wire isRoute = (cfgAddr >= OFF_ROUTE_A) && (cfgAddr <= OFF_ROUTE_D);
   wire [1:0] routeIdx = cfgAddr[1:0];

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         xbusCtlReg <= RST_XBCTL;
         serCtlReg  <= RST_SERCTL; // [RULE_21]
      end else begin
         if (wrXbLo) xbusCtlReg[7:0]  <= cfgWdata & MASK_XBCTL[7:0];
         if (wrXbHi) xbusCtlReg[15:8] <= cfgWdata & MASK_XBCTL[15:8];
         if (wrSer)  serCtlReg        <= cfgWdata; // [RULE_21]
      end
   end

   genvar j, k;
   generate
      for (j = 0; j < 4; j++) begin : g_route
         always_ff @(posedge clk_sys) begin
            if (rst) begin
               routeReg[j] <= RST_ROUTE;
            end else if (cfgWrite && isRoute && (routeIdx == 2'(j))) begin
               routeReg[j] <= cfgWdata & MASK_ROUTE;
            end
         end
      end
   endgenerate

   // Configuration read
   wire [7:0] rdMux = (cfgAddr == OFF_XBCTL_LO) ? xbusCtlReg[7:0]  :
                      (cfgAddr == OFF_XBCTL_HI) ? xbusCtlReg[15:8] :
                      isRoute                   ? routeReg[routeIdx] :
                      (cfgAddr == OFF_SERCTL)   ? serCtlReg : 8'h00;

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         cfgRdata   <= 8'h00;
         cfgRdValid <= 1'b0;
      end else begin
         cfgRdValid <= cfgRead;
         if (cfgRead) cfgRdata <= rdMux;
      end
   end

   // Cycle decode
   wire [15:0] ioA   = cyc.addr[15:0];
   wire        ioCyc = cyc.valid && !cyc.mem;
   wire        pciMem = cyc.valid && cyc.mem && !cyc.isa;
   wire        enMicro = xbusCtlReg[XB_MICRO];
   wire        enKbc   = xbusCtlReg[XB_KBC];
   wire        enRtc   = xbusCtlReg[XB_RTC];
   wire        enApic  = xbusCtlReg[XB_APIC];
   wire        romWrOk = xbusCtlReg[XB_ROMWE];

   wire microHit = ioCyc && enMicro && ((ioA == IO_MICRO_A) || (ioA == IO_MICRO_B)); // [RULE_01]
   wire kbcHit   = ioCyc && enKbc && ((ioA == IO_KBC_DATA) || (ioA == IO_KBC_CMD)); // [RULE_13]
   wire rtcHit   = ioCyc && enRtc && (ioA[15:3] == IO_RTC_BLOCK);                  // [RULE_14]
   wire aliasHit = (ioA == IO_PORT63) || (ioA == IO_PORT65) || (ioA == IO_PORT67);
   wire p61Hit   = ioCyc && ((ioA == IO_PORT61) ||
                             (xbusCtlReg[XB_ALIAS61] && aliasHit));                 // [RULE_11]

   wire in1M   = (cyc.addr >= MEM_1M_LO) && (cyc.addr <= MEM_1M_HI);
   wire inExt  = (cyc.addr >= MEM_EXT_LO) && (cyc.addr <= MEM_EXT_HI);
   wire inLoHi = (cyc.addr[31:16] == MEM_LOWHI_SEG);
   wire inLo   = (cyc.addr[31:16] == MEM_LOW_SEG);
   wire bios1mHit = pciMem && xbusCtlReg[XB_BIOS1M] && in1M;                       // [RULE_02]
   wire extHit    = pciMem && xbusCtlReg[XB_EXTBIOS] && inExt;                     // [RULE_06]
   wire loHiHit   = pciMem && xbusCtlReg[XB_LOWBIOS] && inLoHi;                    // [RULE_07]
   wire loHit     = cyc.valid && cyc.mem && xbusCtlReg[XB_LOWBIOS] && inLo;        // [RULE_08]
   wire romRange  = bios1mHit || extHit || loHiHit || loHit;
   wire romHit    = romRange && (!cyc.write || romWrOk);                           // [RULE_12]
   wire highAlias = bios1mHit || extHit || loHiHit;
   wire apicHit   = pciMem && enApic &&
                    ((cyc.addr[31:4] == MEM_APIC_A[31:4]) ||
                     (cyc.addr[31:4] == MEM_APIC_B[31:4]));                         // [RULE_03] [RULE_04]

   // Shared output enable only for enabled devices
   wire xoeHit = microHit || kbcHit || rtcHit || romHit || apicHit;                // [RULE_15]

   xir_sel_s selNext;
   assign selNext.microcontrollerSelectN = !microHit;
   assign selNext.firmwareRomSelectN     = !romHit;
   assign selNext.xbusOutputEnableN      = !xoeHit;
   assign selNext.ioapicSelectN          = !apicHit;
   assign selNext.keyboardCtrlSelectN    = !kbcHit;
   assign selNext.clockChipSelectN       = !rtcHit;
   assign selNext.clockChipAddrLatch     = rtcHit;
   assign selNext.laHighOnes             = highAlias;                              // [RULE_02]
   assign selNext.forwardIsa             = highAlias || (loHit && !cyc.isa) || apicHit;
   assign selNext.positiveDecode         = microHit && !cyc.isa;                   // [RULE_01]
   assign selNext.port61Hit              = p61Hit;

   // Interrupt routing
   logic [15:0][3:0] routeSel;
   logic [15:0]      routedAny;
   logic [15:0]      routedLvl;
   logic [15:0]      irqNext;

   generate
      for (k = 0; k < 16; k++) begin : g_irq
         for (j = 0; j < 4; j++) begin : g_line
            assign routeSel[k][j] = !routeReg[j][RT_DIS] && IRQ_ROUTABLE[k] &&
                                    (routeReg[j][3:0] == 4'(k));                   // [RULE_16]
         end
         assign routedAny[k] = |routeSel[k];
         assign routedLvl[k] = |(routeSel[k] & ~pciIntLinesN);
         // Own input masked once any line is routed here
         assign irqNext[k] = routedAny[k] ? routedLvl[k] : isaIrqIn[k];           // [RULE_17]
      end
   endgenerate

   wire fpuIrq    = xbusCtlReg[XB_FPU] && !fpuErrorN;                             // [RULE_09]
   wire mouseMode = xbusCtlReg[XB_MOUSE];
   wire [15:0] irqFinal = {irqNext[15:14],
                           irqNext[13] || fpuIrq,
                           irqNext[12] && !(mouseMode && !routedAny[12]),
                           irqNext[11:0]};                                         // [RULE_10]

   // Serial IRQ control
   wire serActive = serCtlReg[SQ_EN] && gcfgSerialIrqEn;                          // [RULE_19]
   wire pulseBusy;
   wire pulseStart = serActive && serialStartReq && serialIrqLineIn && !pulseBusy;

   xir_start_pulse u_start_pulse (
      .clk_sys   (clk_sys),
      .rst       (rst),
      .start     (pulseStart),
      .widthCode (serCtlReg[1:0]),
      .lineOut   (serialIrqLineOut),
      .lineOe    (serialIrqLineOe),
      .busy      (pulseBusy)
   );

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         sel                 <= '1;
         sel.clockChipAddrLatch <= 1'b0;
         sel.laHighOnes      <= 1'b0;
         sel.forwardIsa      <= 1'b0;
         sel.positiveDecode  <= 1'b0;
         sel.port61Hit       <= 1'b0;
         apicPinMode         <= 1'b0;
         ignoreNumericErrorN <= 1'b1;
         irqToCtrl           <= 16'h0000;
         mouseIrq            <= 1'b0;
         serialIrqActive     <= 1'b0;
         serialIrqContinuous <= 1'b0;
      end else begin
         sel                 <= selNext;
         apicPinMode         <= enApic;                                            // [RULE_05]
         ignoreNumericErrorN <= !(fpuIrq && ignNeRequest);                         // [RULE_09]
         irqToCtrl           <= irqFinal;
         mouseIrq            <= mouseMode && !routedAny[12] && isaIrqIn[12];       // [RULE_10]
         serialIrqActive     <= serActive;                                         // [RULE_19]
         serialIrqContinuous <= serCtlReg[SQ_MODE];                                // [RULE_20]
      end
   end

   // Checks
   micro_select_a: assert property (@(posedge clk_sys) disable iff (rst)
      ioCyc && ((ioA == IO_MICRO_A) || (ioA == IO_MICRO_B))
      |=> (sel.microcontrollerSelectN == !$past(enMicro))) // [RULE_01]
      else $error("micro select disagrees with enable");

   bios_1meg_a: assert property (@(posedge clk_sys) disable iff (rst)
      pciMem && in1M && !cyc.write && xbusCtlReg[XB_BIOS1M]
      |=> !sel.firmwareRomSelectN && !sel.xbusOutputEnableN && sel.laHighOnes) // [RULE_02]
      else $error("1-Meg BIOS access not selected");

   apic_isa_a: assert property (@(posedge clk_sys) disable iff (rst)
      cyc.valid && cyc.isa |=> sel.ioapicSelectN) // [RULE_04]
      else $error("APIC select on ISA cycle");

   apic_window_a: assert property (@(posedge clk_sys) disable iff (rst)
      pciMem && (cyc.addr == MEM_APIC_A) |=> (sel.ioapicSelectN != $past(enApic))
      && (sel.forwardIsa == $past(enApic))) // [RULE_03]
      else $error("APIC window select wrong");

   apic_mode_a: assert property (@(posedge clk_sys) disable iff (rst)
      $changed(xbusCtlReg[XB_APIC]) |=> (apicPinMode == $past(xbusCtlReg[XB_APIC]))) // [RULE_05]
      else $error("APIC pin mode lags");

   lower_bios_a: assert property (@(posedge clk_sys) disable iff (rst)
      cyc.valid && cyc.mem && (inLo || inLoHi) && !xbusCtlReg[XB_LOWBIOS]
      |=> sel.firmwareRomSelectN && !sel.forwardIsa) // [RULE_08]
      else $error("lower BIOS decoded while disabled");

   rom_write_a: assert property (@(posedge clk_sys) disable iff (rst)
      cyc.valid && cyc.write && !romWrOk |=> sel.firmwareRomSelectN) // [RULE_12]
      else $error("ROM select on protected write");

   rtc_select_a: assert property (@(posedge clk_sys) disable iff (rst)
      ioCyc && (ioA == 16'h0077) |=> (sel.clockChipAddrLatch == $past(enRtc))
      && (sel.xbusOutputEnableN == !$past(enRtc))) // [RULE_14] [RULE_15]
      else $error("clock chip select wrong");

   kbc_select_a: assert property (@(posedge clk_sys) disable iff (rst)
      ioCyc && (ioA == IO_KBC_CMD) |=> (sel.keyboardCtrlSelectN == !$past(enKbc))) // [RULE_13]
      else $error("keyboard select wrong");

   route_mask_a: assert property (@(posedge clk_sys) disable iff (rst)
      routedAny[5] && (routedLvl[5] == 1'b0) |=> !irqToCtrl[5]) // [RULE_17]
      else $error("routed IRQ input not masked");

   pulse_width_a: assert property (@(posedge clk_sys) disable iff (rst)
      $rose(serialIrqLineOe) && (serCtlReg[1:0] == 2'h1)
      |-> serialIrqLineOe [*6] ##1 !serialIrqLineOe) // [RULE_22]
      else $error("start pulse not six clocks");

   ser_gate_a: assert property (@(posedge clk_sys) disable iff (rst)
      !gcfgSerialIrqEn |=> !serialIrqActive) // [RULE_19]
      else $error("serial IRQ active without general enable");

   pulse_c: cover property (@(posedge clk_sys) disable iff (rst) $rose(serialIrqLineOe));
   rom_c:   cover property (@(posedge clk_sys) disable iff (rst) !sel.firmwareRomSelectN);
   route_c: cover property (@(posedge clk_sys) disable iff (rst) routedAny[11] && routedLvl[11]);
endmodule // xir_bridge_cfg

// File: tb/xir_host_model.sv
// Host bridge model: config byte cycles and decoded cycles.
// Assumes the bench calls its tasks; requests change at the falling edge.
`timescale 1ns/100ps
module xir_host_model (
   input  wire logic         clk_sys,
   output logic              cfgWrite,
   output logic              cfgRead,
   output logic [7:0]        cfgAddr,
   output logic [7:0]        cfgWdata,
   input  wire logic [7:0]   cfgRdata,
   input  wire logic         cfgRdValid,
   output xir_pkg::xir_cyc_s cyc
);
   import xir_pkg::*;
   initial begin
      cfgWrite = 1'b0;
      cfgRead = 1'b0;
      cfgAddr = 8'hFF;
      cfgWdata = 8'hFF;
      cyc = '0;
   end
   // Routed IRQs are level sensitive to this host
   // Frame size kept 0100b; width 11 only on request
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk_sys);
      cfgWrite = 1'b1;
      cfgAddr = a;
      cfgWdata = d;
      @(negedge clk_sys);
      cfgWrite = 1'b0;
      cfgAddr = ~a;
      cfgWdata = ~d;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(negedge clk_sys);
      cfgRead = 1'b1;
      cfgAddr = a;
      for (int i = 0; i < 4; i++) begin
         @(negedge clk_sys);
         cfgRead = 1'b0;
         cfgAddr = ~a;
         if (cfgRdValid === 1'b1) break;
      end
      d = cfgRdata;
   endtask
   // Cycle held valid for two edges, selects then settled
   task automatic go(input logic i, input logic m, input logic w, input logic [31:0] a);
      @(negedge clk_sys);
      cyc = {1'b1, i, m, w, a};
      repeat (2) @(negedge clk_sys);
   endtask
   task automatic stop();
      @(negedge clk_sys);
      cyc = {4'h0, ~cyc.addr};
   endtask
endmodule // xir_host_model

// File: tb/xir_bridge_cfg_tb.sv
// Bench for the X-bus decode and IRQ route slice.
// Assumes the host model drives config and cycle ports; the rest come from here.
`timescale 1ns/100ps
module xir_bridge_cfg_tb;
   import xir_pkg::*;
   localparam logic [10:0] MC = 11'h400, ROM = 11'h200, OEN = 11'h100, APC = 11'h080;
   localparam logic [10:0] KBC = 11'h040, RTC = 11'h020, ALE = 11'h010, LA = 11'h008;
   localparam logic [10:0] FWD = 11'h004, POS = 11'h002, P61 = 11'h001, IDLE = 11'h7E0;
   logic clk_sys = 1'b0;
   logic rst = 1'b1;
   logic cfgWrite, cfgRead, cfgRdValid, apicPinMode, fpuErrorN, ignNeRequest;
   logic ignoreNumericErrorN, mouseIrq, gcfgSerialIrqEn, serialStartReq, serialIrqLineIn;
   logic serialIrqLineOut, serialIrqLineOe, serialIrqActive, serialIrqContinuous;
   logic [7:0] cfgAddr, cfgWdata, cfgRdata;
   logic [3:0] pciIntLinesN;
   logic [15:0] isaIrqIn, irqToCtrl;
   xir_cyc_s cyc;
   xir_sel_s sel;
   int error_cnt = 0;
   int checked = 0;
   int cycles = 0;
   always #4 clk_sys = ~clk_sys;
   assign serialIrqLineIn = serialIrqLineOe ? serialIrqLineOut : 1'b1;
   xir_host_model host (.clk_sys(clk_sys), .cfgWrite(cfgWrite), .cfgRead(cfgRead),
      .cfgAddr(cfgAddr), .cfgWdata(cfgWdata), .cfgRdata(cfgRdata),
      .cfgRdValid(cfgRdValid), .cyc(cyc));
   xir_bridge_cfg dut (.clk_sys(clk_sys), .rst(rst), .cfgWrite(cfgWrite),
      .cfgRead(cfgRead), .cfgAddr(cfgAddr), .cfgWdata(cfgWdata), .cfgRdata(cfgRdata),
      .cfgRdValid(cfgRdValid), .cyc(cyc), .sel(sel), .apicPinMode(apicPinMode),
      .fpuErrorN(fpuErrorN), .ignNeRequest(ignNeRequest),
      .ignoreNumericErrorN(ignoreNumericErrorN), .pciIntLinesN(pciIntLinesN),
      .isaIrqIn(isaIrqIn), .irqToCtrl(irqToCtrl), .mouseIrq(mouseIrq),
      .gcfgSerialIrqEn(gcfgSerialIrqEn), .serialStartReq(serialStartReq),
      .serialIrqLineIn(serialIrqLineIn), .serialIrqLineOut(serialIrqLineOut),
      .serialIrqLineOe(serialIrqLineOe), .serialIrqActive(serialIrqActive),
      .serialIrqContinuous(serialIrqContinuous));
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 20000) begin
         error_cnt++;
         print_verdict();
      end
   end
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checked++;
      if (g !== e) begin
         error_cnt++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
      logic [7:0] d;
      host.rd(a, d);
      chk("cfgRdata", {24'h0, e}, {24'h0, d});
   endtask
   // Selects compared outside the don't-care set
   task automatic dec(input logic i, m, w, input logic [31:0] a, input logic [10:0] act, dc);
      host.go(i, m, w, a);
      chk("sel", {21'h0, (IDLE ^ act) & ~dc}, {21'h0, sel & ~dc});
      host.stop();
   endtask
   task automatic irq(input logic [3:0] p, input logic [15:0] s, input logic [15:0] e);
      @(negedge clk_sys);
      pciIntLinesN = p;
      isaIrqIn = s;
      repeat (2) @(negedge clk_sys);
      chk("irqToCtrl", {16'h0, e}, {16'h0, irqToCtrl});
   endtask
   task automatic pulse(input logic [7:0] ctl, input int e);
      int n;
      n = 0;
      host.wr(8'h64, ctl);
      repeat (2) @(negedge clk_sys);
      serialStartReq = 1'b1;
      @(negedge clk_sys);
      serialStartReq = 1'b0;
      for (int i = 0; i < 16; i++) begin
         if (serialIrqLineOe === 1'b1 && serialIrqLineOut === 1'b0) n++;
         @(negedge clk_sys);
      end
      chk("pulse", e, n);
   endtask
   initial begin
      fpuErrorN = 1'b1;
      ignNeRequest = 1'b0;
      pciIntLinesN = 4'hF;
      isaIrqIn = 16'h0000;
      gcfgSerialIrqEn = 1'b0;
      serialStartReq = 1'b0;
      repeat (12) @(negedge clk_sys);
      rst = 1'b0;
      rdchk(8'h4E, 8'h03);
      rdchk(8'h4F, 8'h00);
      for (int a = 8'h60; a < 8'h64; a++) rdchk(8'(a), 8'h80);
      rdchk(8'h64, 8'h10);
      rdchk(8'h70, 8'h00);
      $display("test reset done");
      dec(0, 0, 0, 32'h64, KBC | OEN, FWD | POS);
      dec(0, 0, 1, 32'h77, RTC | ALE | OEN, FWD | POS);
      dec(0, 0, 0, 32'h78, 11'h0, FWD | POS);
      host.wr(8'h4E, 8'h00);
      dec(0, 0, 0, 32'h60, 11'h0, FWD | POS);
      dec(0, 0, 0, 32'h70, 11'h0, FWD | POS);
      dec(0, 0, 0, 32'h62, 11'h0, FWD);
      dec(0, 1, 0, 32'hFFF00000, 11'h0, FWD | POS | LA);
      dec(0, 1, 0, 32'hFEC00000, 11'h0, POS | LA);
      host.wr(8'h4E, 8'hFF);
      host.wr(8'h4F, 8'h07);
      rdchk(8'h4F, 8'h07);
      dec(0, 0, 0, 32'h66, MC | POS, FWD | OEN);
      dec(0, 1, 0, 32'hFFF7FFFF, ROM | OEN | LA | FWD, POS);
      dec(0, 1, 0, 32'hFFF80000, ROM | OEN | LA | FWD, POS);
      dec(0, 1, 0, 32'hFFFDFFFF, ROM | OEN | LA | FWD, POS);
      dec(1, 1, 0, 32'h000EFFFF, ROM | OEN, POS | LA | FWD);
      dec(0, 1, 0, 32'hFFFE0000, ROM | OEN | LA | FWD, POS);
      dec(0, 1, 1, 32'hFFF00000, ROM | OEN | LA | FWD, POS);
      dec(0, 1, 0, 32'hFEC00010, APC | FWD, OEN | POS | LA);
      dec(1, 1, 0, 32'hFEC00000, 11'h0, OEN | POS | LA | FWD);
      for (int p = 3; p < 8; p += 2) dec(0, 0, 0, 32'h60 + p, P61, FWD | POS | OEN);
      chk("apicPinMode", 1, apicPinMode);
      host.wr(8'h4E, 8'hBB);
      dec(0, 1, 1, 32'hFFF00000, 11'h0, OEN | POS | LA | FWD);
      dec(0, 1, 0, 32'h000E0000, 11'h0, POS | LA);
      dec(0, 1, 0, 32'hFFFE0000, 11'h0, POS | LA);
      host.wr(8'h4F, 8'h00);
      host.wr(8'h4E, 8'h00);
      @(negedge clk_sys);
      chk("apicPinMode", 0, apicPinMode);
      $display("test decode done");
      for (int c = 0; c < 16; c++) begin
         host.wr(8'h60, 8'(c));
         irq(4'hE, 16'h0, IRQ_ROUTABLE[c] ? 16'(1 << c) : 16'h0);
         irq(4'hF, 16'(1 << c), IRQ_ROUTABLE[c] ? 16'h0 : 16'(1 << c));
      end
      host.wr(8'h60, 8'h83);
      irq(4'hE, 16'h0008, 16'h0008);
      for (int a = 8'h60; a < 8'h64; a++) host.wr(8'(a), 8'h05);
      irq(4'hB, 16'h0000, 16'h0020);
      irq(4'hF, 16'h0020, 16'h0000);
      for (int a = 8'h60; a < 8'h64; a++) host.wr(8'(a), 8'h80);
      host.wr(8'h4E, 8'h10);
      irq(4'hF, 16'h1000, 16'h0000);
      chk("mouseIrq", 1, mouseIrq);
      host.wr(8'h4E, 8'h20);
      fpuErrorN = 1'b0;
      ignNeRequest = 1'b1;
      irq(4'hF, 16'h0000, 16'h2000);
      chk("ignoreNumericErrorN", 0, ignoreNumericErrorN);
      host.wr(8'h4E, 8'h00);
      irq(4'hF, 16'h1000, 16'h1000);
      chk("ignoreNumericErrorN", 1, ignoreNumericErrorN);
      $display("test interrupts done");
      host.wr(8'h64, 8'hD0);
      rdchk(8'h64, 8'hD0);
      chk("serialIrqActive", 0, serialIrqActive);
      gcfgSerialIrqEn = 1'b1;
      repeat (2) @(negedge clk_sys);
      chk("serialIrqActive", 1, serialIrqActive);
      chk("serialIrqContinuous", 1, serialIrqContinuous);
      pulse(8'h90, 4);
      pulse(8'h91, 6);
      pulse(8'h92, 8);
      pulse(8'h93, 4);
      chk("serialIrqContinuous", 0, serialIrqContinuous);
      pulse(8'h10, 0);
      $display("test serial done");
      print_verdict();
   end
endmodule // xir_bridge_cfg_tb
